// ==== design/ufsp_user_flash_block.sv ====
// User flash block: serial address and data registers, program/erase engine, oscillator, live update
`timescale 1ns/10ps
// Operation
// - Array holds 512 words of 16 bits, 9-bit address 000h to 1FFh.
// - Address MSB selects sector: 0 lower half, 1 upper half 100h-1FFh.
// - Shift select high: data clock shifts serial input into LSB, MSB outward.
// - Shift select low: data clock loads flash word at current address.
// - Serial data output always shows the data register MSB.
// - Address shift select high: address clock shifts serial address bit in.
// - Address shift select low: address clock increments address, wrapping to zero.
// - Program rising edge writes data register to addressed word; busy until done.
// - Erase rising edge erases sector chosen by address MSB; busy until done.
// - New program or erase requests ignored until busy returns low.
// - Oscillator runs when enabled or during a live update; output held high otherwise.
// - Live-update busy rises, then update waits 500 ms for final access.
// - Register contents need not survive live update.
// - Every read or program acts on the address register location; erase acts on the sector holding it.
// - This port reaches no configuration flash.
// - Oscillator output runs at one quarter of internal oscillator rate.
module ufsp_user_flash_block
#(
   parameter int unsigned ERASE_CYCLES = int'(ufsp_pkg::ERASE_CYC_DEF),
   parameter int unsigned LU_HOLD_CYCLES = int'(ufsp_pkg::LU_HOLD_CYC_DEF),
   parameter int unsigned LU_RUN_CYCLES = int'(ufsp_pkg::LU_RUN_CYC_DEF)
)
(
   // System clock and reset
   input wire logic CLK_I,
   input wire logic RST_I,
   // Address register link
   input wire logic ADDR_REG_CLOCK_I,
   input wire logic ADDR_SERIAL_IN_I,
   input wire logic ADDR_SHIFT_SELECT_I,
   // Data register link
   input wire logic DATA_REG_CLOCK_I,
   input wire logic DATA_SERIAL_IN_I,
   input wire logic DATA_SHIFT_SELECT_I,
   output logic DATA_SERIAL_OUT_O,
   // Program and erase
   input wire logic PROGRAM_I,
   input wire logic ERASE_I,
   output logic BUSY_O,
   // Oscillator
   input wire logic OSCILLATOR_ENABLE_I,
   output logic DIVIDED_CLOCK_OUT_O,
   // Live update
   input wire logic LIVE_UPDATE_REQ_I,
   output logic LIVE_UPDATE_BUSY_O
);
   import ufsp_pkg::*;
   localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(ERASE_CYCLES - 1);
   localparam logic [CNT_W-1:0] LU_HOLD_LAST = CNT_W'(LU_HOLD_CYCLES - 1);
   localparam logic [CNT_W-1:0] LU_RUN_LAST = CNT_W'(LU_RUN_CYCLES - 1);

   // Only the user array exists behind this port, so no address can reach the design image
   logic [DATA_W-1:0] mem [WORDS];
   logic [ADDR_W-1:0] addr_q, next_addr;
   logic [DATA_W-1:0] data_q, next_data;
   logic [N_SYNC-1:0] sync1, sync2, sync3, pins;
   logic [N_SYNC-1:0] next_sync1, next_sync2, next_sync3;
   logic prog_rise, erase_rise, lu_rise;
   ufsp_op_state_t op_state, next_op_state;
   logic [CNT_W-1:0] op_cnt, next_op_cnt;
   logic op_sector, next_op_sector, next_busy, mem_we;
   logic [ADDR_W-1:0] mem_wa;
   logic [DATA_W-1:0] mem_wd;
   ufsp_lu_state_t lu_state, next_lu_state;
   logic [CNT_W-1:0] lu_cnt, next_lu_cnt;
   logic next_lu_busy, lu_active, osc_on;

   // Address register, own clock domain
   always_comb
   begin
      if (ADDR_SHIFT_SELECT_I)
         next_addr = {addr_q[ADDR_W-2:0], ADDR_SERIAL_IN_I};
      else
         next_addr = addr_q + ADDR_STEP;
   end

   always_ff @(posedge ADDR_REG_CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
         addr_q <= ADDR_RESET;
      else
         addr_q <= next_addr;
   end

   // Data register, own clock domain. The array and address are read here without a crossing:
   // the array changes only while busy, when the user stops both clocks and so holds the address still.
   always_comb
   begin
      if (DATA_SHIFT_SELECT_I)
         next_data = {data_q[DATA_MSB-1:0], DATA_SERIAL_IN_I};
      else
         next_data = mem[addr_q];
   end

   always_ff @(posedge DATA_REG_CLOCK_I or posedge RST_I)
   begin
      if (RST_I)
         data_q <= DATA_RESET;
      else
         data_q <= next_data;
   end

   assign DATA_SERIAL_OUT_O = data_q[DATA_MSB];
   // Pin synchronisers; edges are taken from the second and third stages only
   assign pins = {LIVE_UPDATE_REQ_I, OSCILLATOR_ENABLE_I, ERASE_I, PROGRAM_I};
   always_comb
   begin
      next_sync1 = pins;
      next_sync2 = sync1;
      next_sync3 = sync2;
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end
      else
      begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         sync3 <= next_sync3;
      end
   end

   assign prog_rise = sync2[IN_PROG] & ~sync3[IN_PROG];
   assign erase_rise = sync2[IN_ERASE] & ~sync3[IN_ERASE];
   assign lu_rise = sync2[IN_LU] & ~sync3[IN_LU];
   // Program and erase engine
   always_comb
   begin
      next_op_state = op_state;
      next_op_cnt = op_cnt;
      next_op_sector = op_sector;
      mem_we = 1'b0;
      mem_wa = addr_q;
      mem_wd = data_q;
      case (op_state)
         ST_IDLE:
         begin
            // Starts are refused while a live update is pending or running
            if (!lu_active && prog_rise)
            begin
               next_op_state = ST_PROG;
               next_op_cnt = CNT_ZERO;
               mem_we = 1'b1;
            end
            else if (!lu_active && erase_rise)
            begin
               next_op_state = ST_ERASE;
               next_op_cnt = CNT_ZERO;
               next_op_sector = addr_q[SECTOR_BIT];
            end
         end
         ST_PROG:
         begin
            if (op_cnt == PROG_LAST)
               next_op_state = ST_IDLE;
            else
               next_op_cnt = op_cnt + CNT_ONE;
         end
         ST_ERASE:
         begin
            // One word per cycle over the sector, then the remaining erase time
            if (op_cnt < CNT_SECTOR)
            begin
               mem_we = 1'b1;
               mem_wa = {op_sector, op_cnt[SECTOR_BIT-1:0]};
               mem_wd = ERASED_WORD;
            end
            if (op_cnt == ERASE_LAST)
               next_op_state = ST_IDLE;
            else
               next_op_cnt = op_cnt + CNT_ONE;
         end
         default:
         begin
            next_op_state = ST_IDLE;
         end
      endcase
      next_busy = (next_op_state != ST_IDLE);
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         op_state <= ST_IDLE;
         op_cnt <= CNT_ZERO;
         op_sector <= 1'b0;
         BUSY_O <= 1'b0;
      end
      else
      begin
         op_state <= next_op_state;
         op_cnt <= next_op_cnt;
         op_sector <= next_op_sector;
         BUSY_O <= next_busy;
      end
   end

   // Flash contents hold no reset value
   always_ff @(posedge CLK_I)
   begin
      if (mem_we)
         mem[mem_wa] <= mem_wd;
   end
   // Live update: hold window for a last access, then the update itself.
   // Registers are not restored afterwards.
   always_comb
   begin
      next_lu_state = lu_state;
      next_lu_cnt = lu_cnt;
      case (lu_state)
         LU_IDLE:
         begin
            if (lu_rise)
            begin
               next_lu_state = LU_WAIT;
               next_lu_cnt = CNT_ZERO;
            end
         end
         LU_WAIT:
         begin
            if (lu_cnt == LU_HOLD_LAST)
            begin
               next_lu_state = LU_RUN;
               next_lu_cnt = CNT_ZERO;
            end
            else
               next_lu_cnt = lu_cnt + CNT_ONE;
         end
         LU_RUN:
         begin
            if (lu_cnt == LU_RUN_LAST)
               next_lu_state = LU_IDLE;
            else
               next_lu_cnt = lu_cnt + CNT_ONE;
         end
         default:
         begin
            next_lu_state = LU_IDLE;
         end
      endcase
      next_lu_busy = (next_lu_state != LU_IDLE);
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         lu_state <= LU_IDLE;
         lu_cnt <= CNT_ZERO;
         LIVE_UPDATE_BUSY_O <= 1'b0;
      end
      else
      begin
         lu_state <= next_lu_state;
         lu_cnt <= next_lu_cnt;
         LIVE_UPDATE_BUSY_O <= next_lu_busy;
      end
   end

   assign lu_active = (lu_state != LU_IDLE);
   // The oscillator also runs on its own during a live update
   assign osc_on = sync2[IN_OSC] | lu_active;
   ufsp_osc_div u_osc
   (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .enable_i(osc_on),
      .div_o(DIVIDED_CLOCK_OUT_O)
   );

   sequence s_prog_start;
      op_state == ST_IDLE && !lu_active && prog_rise;
   endsequence
   sequence s_prog_running;
      op_state == ST_PROG && BUSY_O;
   endsequence
   property p_prog_start;
      @(posedge CLK_I) disable iff (RST_I)
      s_prog_start |-> mem_we && mem_wa == addr_q && mem_wd == data_q ##1 s_prog_running;
   endproperty
   a_prog_start: assert property (p_prog_start) else $error("program start not taken");
   property p_prog_end;
      @(posedge CLK_I) disable iff (RST_I)
      (op_state == ST_PROG && op_cnt == PROG_LAST) |=> op_state == ST_IDLE && !BUSY_O;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("program time wrong");
   property p_erase_sector;
      @(posedge CLK_I) disable iff (RST_I)
      (op_state == ST_ERASE && mem_we) |-> mem_wa[SECTOR_BIT] == op_sector && mem_wd == ERASED_WORD;
   endproperty
   a_erase_sector: assert property (p_erase_sector) else $error("erase left its sector");
   property p_erase_latch;
      @(posedge CLK_I) disable iff (RST_I)
      (op_state == ST_IDLE && !lu_active && !prog_rise && erase_rise) |=>
         op_state == ST_ERASE && BUSY_O && op_sector == $past(addr_q[SECTOR_BIT]);
   endproperty
   a_erase_latch: assert property (p_erase_latch) else $error("erase sector not latched");
   // A request seen mid-operation must neither restart the count nor switch the operation
   property p_ignore_new;
      @(posedge CLK_I) disable iff (RST_I)
      (op_state != ST_IDLE && next_op_state != ST_IDLE && (prog_rise || erase_rise)) |=>
         op_state == $past(op_state) && op_cnt == $past(op_cnt) + CNT_ONE;
   endproperty
   a_ignore_new: assert property (p_ignore_new) else $error("request taken while busy");
   property p_idle_not_busy;
      @(posedge CLK_I) disable iff (RST_I)
      op_state == ST_IDLE |-> !BUSY_O;
   endproperty
   a_idle_not_busy: assert property (p_idle_not_busy) else $error("busy while idle");
   property p_lu_hold;
      @(posedge CLK_I) disable iff (RST_I)
      (lu_state == LU_WAIT && lu_cnt != LU_HOLD_LAST) |=> lu_state == LU_WAIT && LIVE_UPDATE_BUSY_O;
   endproperty
   a_lu_hold: assert property (p_lu_hold) else $error("live update hold cut short");
   property p_addr_step;
      @(posedge ADDR_REG_CLOCK_I) disable iff (RST_I)
      !ADDR_SHIFT_SELECT_I |=> addr_q == $past(addr_q) + ADDR_STEP;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address not incremented");
   property p_data_shift;
      @(posedge DATA_REG_CLOCK_I) disable iff (RST_I)
      DATA_SHIFT_SELECT_I |=> data_q == {$past(data_q[DATA_MSB-1:0]), $past(DATA_SERIAL_IN_I)};
   endproperty
   a_data_shift: assert property (p_data_shift) else $error("data not shifted");
endmodule

// ==== design/ufsp_pkg.sv ====
// Constants, timing figures and state types for the user flash serial port
package ufsp_pkg;
   // Array geometry
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;
   localparam int WORDS = 512;
   localparam int SECTOR_BIT = 8;
   localparam int DATA_MSB = 15;
   localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
   localparam logic [ADDR_W-1:0] ADDR_STEP = 9'h001;

   // Timing, system clock at 10 MHz
   localparam longint unsigned CLK_HZ = 64'd10000000;
   localparam longint unsigned PROG_TIME_US = 64'd75;
   localparam longint unsigned ERASE_TIME_MS = 64'd500;
   localparam longint unsigned LU_HOLD_MS = 64'd500;
   localparam longint unsigned PROG_CYC = (PROG_TIME_US * CLK_HZ + 64'd999999) / 64'd1000000;
   localparam longint unsigned ERASE_CYC_DEF = (ERASE_TIME_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam longint unsigned LU_HOLD_CYC_DEF = (LU_HOLD_MS * CLK_HZ + 64'd999) / 64'd1000;
   localparam longint unsigned LU_RUN_CYC_DEF = 64'd1000;

   // Counters
   localparam int CNT_W = 23;
   localparam logic [CNT_W-1:0] CNT_ZERO = 23'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 23'h000001;
   localparam logic [CNT_W-1:0] CNT_SECTOR = 23'h000100;
   localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYC - 64'd1);

   // Synchronised pin inputs
   localparam int N_SYNC = 4;
   localparam int IN_PROG = 0;
   localparam int IN_ERASE = 1;
   localparam int IN_OSC = 2;
   localparam int IN_LU = 3;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_PROG = 3'b010,
      ST_ERASE = 3'b100
   } ufsp_op_state_t;

   typedef enum logic [2:0]
   {
      LU_IDLE = 3'b001,
      LU_WAIT = 3'b010,
      LU_RUN = 3'b100
   } ufsp_lu_state_t;
endpackage

// ==== design/ufsp_osc_div.sv ====
// Divide-by-four oscillator output with a stopped-high state
`timescale 1ns/10ps
module ufsp_osc_div
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic enable_i,
   // Output
   output logic div_o
);
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   logic next_div;

   // Starting from the high level keeps the first enabled period free of a runt pulse
   always_comb
   begin
      next_cnt = enable_i ? cnt + 2'h1 : 2'h0;
      next_div = enable_i ? ~next_cnt[1] : 1'b1;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt <= 2'h0;
         div_o <= 1'b1;
      end
      else
      begin
         cnt <= next_cnt;
         div_o <= next_div;
      end
   end

   property p_osc_stop;
      @(posedge clk_i) disable iff (rst_i)
      (!enable_i)[*2] |-> div_o;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("stopped oscillator not high");

   property p_osc_quarter;
      @(posedge clk_i) disable iff (rst_i)
      (enable_i && $past(enable_i) && $changed(div_o)) |=> !enable_i || $stable(div_o)
         ##1 !enable_i || $changed(div_o);
   endproperty
   a_osc_quarter: assert property (p_osc_quarter) else $error("oscillator not divided by four");
endmodule

// ==== verif/ufsp_link_model.sv ====
// Model of the user logic that clocks the serial address and data registers
`timescale 1ns/10ps
module ufsp_link_model
(
   // Address register link
   output logic addr_clk,
   output logic addr_in,
   output logic addr_sel,
   // Data register link
   output logic data_clk,
   output logic data_in,
   output logic data_sel,
   // Status from the flash block
   input wire logic data_out,
   input wire logic busy,
   input wire logic lu_busy
);
   localparam time HALF = 15ns;
   // Each short pulse is followed by idle time, so rising edges stay 100 ns apart
   localparam time GAP = 70ns;
   initial
   begin
      addr_clk = 1'b0;
      addr_in = 1'b0;
      addr_sel = 1'b1;
      data_clk = 1'b0;
      data_in = 1'b0;
      data_sel = 1'b1;
   end
   // Clocking while busy would read the array while the operation in flight changes it
   task automatic wait_idle();
      while (busy === 1'b1 || lu_busy === 1'b1)
         #HALF;
   endtask
   task automatic addr_pulse(input logic sel, input logic b);
      addr_sel = sel;
      addr_in = b;
      #HALF;
      addr_clk = 1'b1;
      #HALF;
      addr_clk = 1'b0;
      #GAP;
   endtask
   task automatic send_addr(input logic [8:0] a);
      wait_idle();
      for (int i = 8; i >= 0; i--)
         addr_pulse(1'b1, a[i]);
      // Released line shows the inverse so a stale bit is never mistaken for data
      addr_in = ~a[0];
   endtask
   task automatic step_addr();
      wait_idle();
      addr_pulse(1'b0, 1'b0);
   endtask
   task automatic data_pulse(input logic sel, input logic b, output logic o);
      data_sel = sel;
      data_in = b;
      #HALF;
      data_clk = 1'b1;
      #5;
      o = data_out;
      #10;
      data_clk = 1'b0;
      #GAP;
   endtask
   // MSB goes in first; seen holds the serial output after each edge
   task automatic shift_word(input logic [15:0] d, output logic [15:0] seen);
      wait_idle();
      for (int i = 15; i >= 0; i--)
         data_pulse(1'b1, d[i], seen[i]);
      data_in = ~d[0];
   endtask
   task automatic read_word(output logic [15:0] w);
      wait_idle();
      data_pulse(1'b0, 1'b0, w[15]);
      for (int i = 14; i >= 0; i--)
         data_pulse(1'b1, 1'b0, w[i]);
      data_in = 1'b1;
   endtask
endmodule

// ==== verif/ufsp_user_flash_block_bench.sv ====
// Self-checking bench for the user flash serial port
`timescale 1ns/10ps
module ufsp_user_flash_block_bench;
   import ufsp_pkg::*;
   localparam int unsigned ERASE_N = 300;
   localparam int unsigned HOLD_N = 20;
   localparam int unsigned RUN_N = 10;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic prog_pin = 1'b0;
   logic erase_pin = 1'b0;
   logic osc_en = 1'b0;
   logic lu_req = 1'b0;
   logic addr_clk, addr_in, addr_sel, data_clk, data_in, data_sel;
   logic data_out, busy, div_clk, lu_busy;
   int n_errors = 0;
   int checked = 0;
   always #50 clk = ~clk;
   ufsp_user_flash_block #(.ERASE_CYCLES(ERASE_N), .LU_HOLD_CYCLES(HOLD_N), .LU_RUN_CYCLES(RUN_N)) i_dut
   (
      .CLK_I(clk), .RST_I(rst),
      .ADDR_REG_CLOCK_I(addr_clk), .ADDR_SERIAL_IN_I(addr_in), .ADDR_SHIFT_SELECT_I(addr_sel),
      .DATA_REG_CLOCK_I(data_clk), .DATA_SERIAL_IN_I(data_in), .DATA_SHIFT_SELECT_I(data_sel),
      .DATA_SERIAL_OUT_O(data_out), .PROGRAM_I(prog_pin), .ERASE_I(erase_pin), .BUSY_O(busy),
      .OSCILLATOR_ENABLE_I(osc_en), .DIVIDED_CLOCK_OUT_O(div_clk),
      .LIVE_UPDATE_REQ_I(lu_req), .LIVE_UPDATE_BUSY_O(lu_busy)
   );
   ufsp_link_model i_link
   (
      .addr_clk(addr_clk), .addr_in(addr_in), .addr_sel(addr_sel),
      .data_clk(data_clk), .data_in(data_in), .data_sel(data_sel),
      .data_out(data_out), .busy(busy), .lu_busy(lu_busy)
   );
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Counts busy cycles; poke raises erase mid-operation, which must be dropped
   task automatic run_op(input logic erase, input logic poke, output int n);
      n = 0;
      @(negedge clk);
      erase_pin = erase;
      prog_pin = ~erase;
      for (int i = 0; i < 8 && busy !== 1'b1; i++)
         @(negedge clk);
      while (busy === 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
         if (poke && n == 100)
            erase_pin = 1'b1;
      end
      prog_pin = 1'b0;
      erase_pin = 1'b0;
   endtask
   task automatic read_at(input logic [8:0] a, input logic [15:0] exp, input string what);
      logic [15:0] w;
      i_link.send_addr(a);
      i_link.read_word(w);
      check(what, w, exp);
   endtask
   task automatic t_reset();
      check("busy", {15'h0, busy}, 16'h0000);
      check("live update busy", {15'h0, lu_busy}, 16'h0000);
      check("divided clock", {15'h0, div_clk}, 16'h0001);
      check("serial out", {15'h0, data_out}, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_erase();
      int n;
      i_link.send_addr(9'h1A5);
      run_op(1'b1, 1'b0, n);
      check("erase busy cycles", 16'(n), 16'(ERASE_N));
      i_link.send_addr(9'h0FF);
      run_op(1'b1, 1'b0, n);
      check("erase busy cycles", 16'(n), 16'(ERASE_N));
      read_at(9'h100, ERASED_WORD, "sector 1 first");
      read_at(9'h1FF, ERASED_WORD, "sector 1 last");
      read_at(9'h000, ERASED_WORD, "sector 0 first");
      $display("test erase done");
   endtask
   task automatic t_program();
      logic [15:0] seen;
      int n;
      i_link.send_addr(9'h1FF);
      i_link.shift_word(16'hA5C3, seen);
      run_op(1'b0, 1'b0, n);
      check("program busy cycles", 16'(n), 16'(PROG_CYC));
      i_link.send_addr(9'h000);
      i_link.shift_word(16'h1234, seen);
      run_op(1'b0, 1'b1, n);
      repeat (10) @(negedge clk);
      check("busy after dropped erase", {15'h0, busy}, 16'h0000);
      read_at(9'h1FF, 16'hA5C3, "word 1FF");
      read_at(9'h100, ERASED_WORD, "word 100");
      read_at(9'h000, 16'h1234, "word 000");
      $display("test program done");
   endtask
   task automatic t_stream();
      logic [15:0] w;
      logic [15:0] seen;
      i_link.send_addr(9'h1FE);
      i_link.step_addr();
      i_link.read_word(w);
      check("word after step", w, 16'hA5C3);
      i_link.step_addr();
      i_link.read_word(w);
      check("word after wrap", w, 16'h1234);
      i_link.shift_word(16'h3C5A, seen);
      i_link.shift_word(16'h8001, seen);
      check("shifted out", seen, 16'h78B5);
      $display("test stream done");
   endtask
   task automatic t_osc();
      logic [7:0] s;
      @(negedge clk);
      osc_en = 1'b1;
      repeat (6) @(negedge clk);
      for (int i = 0; i < 8; i++)
      begin
         s[i] = div_clk;
         @(negedge clk);
      end
      for (int i = 2; i < 8; i++)
         check("divided clock", {15'h0, s[i]}, {15'h0, ~s[i-2]});
      osc_en = 1'b0;
      repeat (6) @(negedge clk);
      for (int i = 0; i < 4; i++)
      begin
         check("stopped clock", {15'h0, div_clk}, 16'h0001);
         @(negedge clk);
      end
      $display("test oscillator done");
   endtask
   task automatic t_live();
      int n;
      n = 0;
      @(negedge clk);
      lu_req = 1'b1;
      for (int i = 0; i < 8 && lu_busy !== 1'b1; i++)
         @(negedge clk);
      while (lu_busy === 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      lu_req = 1'b0;
      check("live update cycles", 16'(n), 16'(HOLD_N + RUN_N));
      $display("test live update done");
   endtask
   initial
   begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_erase();
      t_program();
      t_stream();
      t_osc();
      t_live();
      print_verdict();
   end
   initial
   begin
      #2000000;
      n_errors++;
      $display("watchdog expired");
      print_verdict();
   end
endmodule
